/* hdl/four_port_map.vh */
// Register map and reset values for the four-port parallel I/O block.
// Assumes an APB slave with 32-bit data and one register per word.
`ifndef FOUR_PORT_MAP_VH
`define FOUR_PORT_MAP_VH

// Register indices; byte address is four times the index
`define IDX_PORT_A_OUT 6'h00
`define IDX_PORT_B_OUT 6'h01
`define IDX_PORT_C_OUT 6'h02
`define IDX_PORT_D_OUT 6'h03
`define IDX_PORT_A_DIR 6'h08
`define IDX_PORT_B_DIR 6'h09
`define IDX_PORT_D_DIR 6'h0B
`define IDX_PORT_C_PIN 6'h0C
`define IDX_SYS_CTL_ONE 6'h38
`define IDX_SYS_CTL_TWO 6'h39

// Reset values
`define RST_PORT_A_OUT 8'h00
`define RST_PORT_B_OUT 8'h00
`define RST_PORT_C_OUT 3'h7
`define RST_PORT_D_OUT 8'hFF
`define RST_DIR 8'h00
`define RST_SYS_CTL_ONE 8'h00
`define RST_SYS_CTL_TWO 8'h00

// Field positions
`define BIT_STOP 7
`define BIT_STOP_OUT_EN 4
`define BIT_LOW_OSC_EN 6
`define PIN_STOP_RELEASE 0
`define PIN_LOW_OSC_IN 1
`define PIN_LOW_OSC_OUT 2

// Low-frequency oscillator rate, Hz
`define LOW_OSC_HZ 32768

`endif

/* hdl/four_port_io.v */
// Four parallel I/O ports with APB register access.
// Assumes pins are synchronous to CLK_SYS; the board resolves each pin
// wire from the OUT and OE signals given here.
//
// Contract
// - Each bit of ports A, B, D selectable
// - Direction 0 means input; A reset clears
// - Port A latches reset to zero
// - Port B direction resets to input
// - Port B latches reset to zero
// - Port C three pins, latches reset high
// - Port C latch and pins separate addresses
// - Port C upper read bits undefined
// - Dual-clock mode gives C pins to oscillator
// - Stop mode floats C pin zero always
// - Port D direction resets to input
// - Port D latches reset to ones
// - Read-modify-write reads pins of input bits
// - Port B latch 0x01, direction 0x09
// - Stop bit 7, output enable bit 4
// - Pins sampled at read, change at write

`include "four_port_map.vh"

module four_port_io #(
  parameter A_WIDTH = 8,
  parameter C_WIDTH = 3
) (
  // Clock and reset
  input wire CLK_SYS,
  input wire RST_N,
  // APB slave
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  input wire [3:0] PSTRB,
  output wire [31:0] PRDATA,
  output wire PREADY,
  output wire PSLVERR,
  // Port A pins
  input wire [A_WIDTH-1:0] PA_IN,
  output wire [A_WIDTH-1:0] PA_OUT,
  output wire [A_WIDTH-1:0] PA_OE,
  // Port B pins
  input wire [A_WIDTH-1:0] PB_IN,
  output wire [A_WIDTH-1:0] PB_OUT,
  output wire [A_WIDTH-1:0] PB_OE,
  // Port C pins, open drain
  input wire [C_WIDTH-1:0] PC_IN,
  output wire [C_WIDTH-1:0] PC_OUT,
  output wire [C_WIDTH-1:0] PC_OE,
  // Port D pins
  input wire [A_WIDTH-1:0] PD_IN,
  output wire [A_WIDTH-1:0] PD_OUT,
  output wire [A_WIDTH-1:0] PD_OE,
  // System state
  output wire STOP_MODE,
  output wire LOW_OSC_ENABLE
);

  reg [A_WIDTH-1:0] port_a_out_latch_reg;
  reg [A_WIDTH-1:0] port_b_out_latch_reg;
  reg [C_WIDTH-1:0] port_c_out_latch_reg;
  reg [A_WIDTH-1:0] port_d_out_latch_reg;
  reg [A_WIDTH-1:0] port_a_dir_ctl_reg;
  reg [A_WIDTH-1:0] port_b_dir_ctl_reg;
  reg [A_WIDTH-1:0] port_d_dir_ctl_reg;
  reg [7:0] system_ctl_one_reg;
  reg [7:0] system_ctl_two_reg;
  reg [31:0] rdata_reg;
  reg [31:0] rdata_next;
  reg hit_reg;
  reg hit_next;

  wire [5:0] idx;
  wire setup;
  wire access;
  wire wr_en;
  wire [7:0] wbyte;
  wire stop_mode;
  wire stop_out_en;
  wire low_osc_en;
  wire drivers_off;
  wire [A_WIDTH-1:0] port_a_view;
  wire [A_WIDTH-1:0] port_b_view;
  wire [A_WIDTH-1:0] port_d_view;
  wire [C_WIDTH-1:0] port_c_pin_input;
  wire [C_WIDTH-1:0] c_taken;
  wire we_port_a_out;
  wire we_port_b_out;
  wire we_port_c_out;
  wire we_port_d_out;
  wire we_port_a_dir;
  wire we_port_b_dir;
  wire we_port_d_dir;
  wire we_sys_ctl_one;
  wire we_sys_ctl_two;

  assign idx = PADDR[7:2];
  assign setup = PSEL & ~PENABLE;
  assign access = PSEL & PENABLE;
  // Only the low byte lane holds register data
  assign wr_en = access & PWRITE & PSTRB[0] & hit_reg;
  assign wbyte = PWDATA[7:0];

  // One strobe per writable register, none for the read-only port C pin word; an unmapped word writes nothing
  assign we_port_a_out = wr_en & (idx == `IDX_PORT_A_OUT);
  assign we_port_b_out = wr_en & (idx == `IDX_PORT_B_OUT);
  assign we_port_c_out = wr_en & (idx == `IDX_PORT_C_OUT);
  assign we_port_d_out = wr_en & (idx == `IDX_PORT_D_OUT);
  assign we_port_a_dir = wr_en & (idx == `IDX_PORT_A_DIR);
  assign we_port_b_dir = wr_en & (idx == `IDX_PORT_B_DIR);
  assign we_port_d_dir = wr_en & (idx == `IDX_PORT_D_DIR);
  assign we_sys_ctl_one = wr_en & (idx == `IDX_SYS_CTL_ONE);
  assign we_sys_ctl_two = wr_en & (idx == `IDX_SYS_CTL_TWO);

  assign stop_mode = system_ctl_one_reg[`BIT_STOP];
  assign stop_out_en = system_ctl_one_reg[`BIT_STOP_OUT_EN];
  assign low_osc_en = system_ctl_two_reg[`BIT_LOW_OSC_EN];
  assign drivers_off = stop_mode & ~stop_out_en;

  // Input-mode bits read the pin, output-mode bits the latch
  assign port_a_view = (port_a_dir_ctl_reg & port_a_out_latch_reg)
                     | (~port_a_dir_ctl_reg & PA_IN);
  assign port_b_view = (port_b_dir_ctl_reg & port_b_out_latch_reg)
                     | (~port_b_dir_ctl_reg & PB_IN);
  assign port_d_view = (port_d_dir_ctl_reg & port_d_out_latch_reg)
                     | (~port_d_dir_ctl_reg & PD_IN);

  // Oscillator pins leave port use in dual-clock mode
  assign c_taken = low_osc_en ?
    ((3'h1 << `PIN_LOW_OSC_IN) | (3'h1 << `PIN_LOW_OSC_OUT)) : 3'h0;
  assign port_c_pin_input = PC_IN & ~c_taken;

  // Address decode and read data, captured in the setup cycle
  always @* begin
    hit_next = 1'h1;
    rdata_next = 32'h0000_0000;
    case (idx)
      `IDX_PORT_A_OUT: begin
        rdata_next[A_WIDTH-1:0] = port_a_view;
      end
      `IDX_PORT_B_OUT: begin
        rdata_next[A_WIDTH-1:0] = port_b_view;
      end
      `IDX_PORT_C_OUT: begin
        // Upper bits carry no meaning; they read zero here
        rdata_next[C_WIDTH-1:0] = port_c_out_latch_reg;
      end
      `IDX_PORT_C_PIN: begin
        rdata_next[C_WIDTH-1:0] = port_c_pin_input;
      end
      `IDX_PORT_D_OUT: begin
        rdata_next[A_WIDTH-1:0] = port_d_view;
      end
      `IDX_PORT_A_DIR: begin
        rdata_next[A_WIDTH-1:0] = port_a_dir_ctl_reg;
      end
      `IDX_PORT_B_DIR: begin
        rdata_next[A_WIDTH-1:0] = port_b_dir_ctl_reg;
      end
      `IDX_PORT_D_DIR: begin
        rdata_next[A_WIDTH-1:0] = port_d_dir_ctl_reg;
      end
      `IDX_SYS_CTL_ONE: begin
        rdata_next[7:0] = system_ctl_one_reg;
      end
      `IDX_SYS_CTL_TWO: begin
        rdata_next[7:0] = system_ctl_two_reg;
      end
      default: begin
        hit_next = 1'h0;
      end
    endcase
  end

  // Pins are sampled at the setup edge, the first state of the read
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rdata_reg <= 32'h0000_0000;
      hit_reg <= 1'h0;
    end else if (setup) begin
      rdata_reg <= rdata_next;
      hit_reg <= hit_next;
    end
  end

  // Register writes take effect at the access edge
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      port_a_out_latch_reg <= `RST_PORT_A_OUT;
    end else if (we_port_a_out) begin
      port_a_out_latch_reg <= wbyte[A_WIDTH-1:0];
    end
  end

  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      port_b_out_latch_reg <= `RST_PORT_B_OUT;
    end else if (we_port_b_out) begin
      port_b_out_latch_reg <= wbyte[A_WIDTH-1:0];
    end
  end

  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      port_c_out_latch_reg <= `RST_PORT_C_OUT;
    end else if (we_port_c_out) begin
      port_c_out_latch_reg <= wbyte[C_WIDTH-1:0];
    end
  end

  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      port_d_out_latch_reg <= `RST_PORT_D_OUT;
    end else if (we_port_d_out) begin
      port_d_out_latch_reg <= wbyte[A_WIDTH-1:0];
    end
  end

  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      port_a_dir_ctl_reg <= `RST_DIR;
    end else if (we_port_a_dir) begin
      port_a_dir_ctl_reg <= wbyte[A_WIDTH-1:0];
    end
  end

  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      port_b_dir_ctl_reg <= `RST_DIR;
    end else if (we_port_b_dir) begin
      port_b_dir_ctl_reg <= wbyte[A_WIDTH-1:0];
    end
  end

  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      port_d_dir_ctl_reg <= `RST_DIR;
    end else if (we_port_d_dir) begin
      port_d_dir_ctl_reg <= wbyte[A_WIDTH-1:0];
    end
  end

  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      system_ctl_one_reg <= `RST_SYS_CTL_ONE;
    end else if (we_sys_ctl_one) begin
      system_ctl_one_reg <= wbyte;
    end
  end

  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      system_ctl_two_reg <= `RST_SYS_CTL_TWO;
    end else if (we_sys_ctl_two) begin
      system_ctl_two_reg <= wbyte;
    end
  end

  // Bus answer: no wait states, error on unmapped words
  assign PREADY = 1'h1;
  assign PSLVERR = access & ~hit_reg;
  assign PRDATA = rdata_reg;

  // Latches drive the pads directly
  assign PA_OUT = port_a_out_latch_reg;
  assign PB_OUT = port_b_out_latch_reg;
  assign PD_OUT = port_d_out_latch_reg;
  // Open drain: only a 0 in the latch pulls the pin
  assign PC_OUT = {C_WIDTH{1'h0}};

  // Driver enables, one per pin
  genvar i;
  generate
    for (i = 0; i < A_WIDTH; i = i + 1) begin : g_pin
      assign PA_OE[i] = port_a_dir_ctl_reg[i] & ~drivers_off;
      assign PB_OE[i] = port_b_dir_ctl_reg[i] & ~drivers_off;
      assign PD_OE[i] = port_d_dir_ctl_reg[i] & ~drivers_off;
    end
    for (i = 0; i < C_WIDTH; i = i + 1) begin : g_pin_c
      if (i == `PIN_STOP_RELEASE) begin : g_rel
        // Must stay an input so the stop-release edge can be seen
        assign PC_OE[i] = ~port_c_out_latch_reg[i] & ~stop_mode
                        & ~c_taken[i];
      end else begin : g_norm
        assign PC_OE[i] = ~port_c_out_latch_reg[i] & ~drivers_off
                        & ~c_taken[i];
      end
    end
  endgenerate

  assign STOP_MODE = stop_mode;
  assign LOW_OSC_ENABLE = low_osc_en;

endmodule

/* bench/pin_board.sv */
// Board side of one port: resolves each pin wire.
// Assumes an enabled driver always wins over the board level.
module pin_board #(
  parameter W = 8
) (
  // Board level and design driver
  input logic [W-1:0] ext,
  input logic [W-1:0] drv,
  input logic [W-1:0] oe,
  // Resolved level
  output logic [W-1:0] pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Released pins show the board level, never the last driven value
  assign pin = (oe & drv) | (~oe & ext);
endmodule

/* bench/four_port_io_asserts.sv */
// Port-level checker for the four-port I/O block.
// Assumes zero-wait APB and the byte addresses of the register map.
module four_port_io_asserts #(
  parameter A_WIDTH = 8,
  parameter C_WIDTH = 3
) (
  // Clock, reset and APB
  input logic CLK_SYS,
  input logic RST_N,
  input logic PSEL,
  input logic PENABLE,
  input logic PWRITE,
  input logic [7:0] PADDR,
  input logic [31:0] PWDATA,
  input logic [3:0] PSTRB,
  input logic [31:0] PRDATA,
  input logic PSLVERR,
  // Pins and state
  input logic [A_WIDTH-1:0] PA_OE,
  input logic [A_WIDTH-1:0] PB_OUT,
  input logic [C_WIDTH-1:0] PC_IN,
  input logic [C_WIDTH-1:0] PC_OE,
  input logic STOP_MODE,
  input logic LOW_OSC_ENABLE
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  logic wr, mapped;
  logic [7:0] wb;
  logic [C_WIDTH-1:0] wc;
  assign wr = PSEL && PENABLE && PWRITE && PSTRB[0];
  assign wb = PWDATA[7:0];
  assign wc = PWDATA[C_WIDTH-1:0];
  assign mapped = PADDR[7:2] inside {6'h00, 6'h01, 6'h02, 6'h03, 6'h08, 6'h09, 6'h0B,
    6'h0C, 6'h38, 6'h39};
  chk_err_unmapped: assert property (PSEL && PENABLE |-> PSLVERR == !mapped)
    else $error("error response does not match decode");
  chk_dir_drives: assert property (wr && PADDR == 8'h20 && !STOP_MODE |=> PA_OE == $past(wb))
    else $error("driver enable does not follow direction write");
  chk_b_latch: assert property (wr && PADDR == 8'h04 |=> PB_OUT == $past(wb))
    else $error("second port latch not written");
  chk_c_open_drain: assert property (wr && PADDR == 8'h08 && !STOP_MODE &&
    !LOW_OSC_ENABLE |=> PC_OE == ~$past(wc)) else $error("third port pull-down wrong");
  chk_stop_release: assert property (STOP_MODE |-> !PC_OE[0])
    else $error("stop release pin driven in stop");
  chk_osc_pins: assert property (LOW_OSC_ENABLE |-> PC_OE[2:1] == 2'h0)
    else $error("oscillator pins driven");
  chk_pin_sample: assert property (PSEL && !PENABLE && !PWRITE && PADDR == 8'h30 &&
    !LOW_OSC_ENABLE |=> PRDATA[C_WIDTH-1:0] == $past(PC_IN)) else $error("pin read wrong");
  chk_stop_float: assert property (wr && PADDR == 8'hE0 && wb[7] && !wb[4] |=> PA_OE == '0)
    else $error("outputs driven in stop");
  cover property (wr && PADDR == 8'hE0);
  cover property (PSEL && PENABLE && !mapped);
  cover property (LOW_OSC_ENABLE && PSEL && PADDR == 8'h30);
endmodule

/* bench/tb_top.sv */
// Self-checking bench for the four-port I/O block.
// Assumes a zero-wait APB slave and a board model on every port.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic low_osc, stop;
  logic [7:0] paddr = 8'h00, dir, lat;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic [7:0] ext[3] = '{8'h00, 8'h00, 8'h00};
  logic [7:0] dirs[3] = '{8'h20, 8'h24, 8'h2C};
  logic [7:0] dats[3] = '{8'h00, 8'h04, 8'h0C};
  logic [7:0] roles[3] = '{8'h0F, 8'h18, 8'hA8};
  logic [2:0] ec = 3'h0;
  wire [2:0] c_in, c_out, c_oe;
  wire [7:0] outs[3], oes[3], pins[3];
  int miscompares = 0, samples_checked = 0;
  four_port_io u_four_port_io (.CLK_SYS(clk_sys), .RST_N(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PA_IN(pins[0]), .PA_OUT(outs[0]),
    .PA_OE(oes[0]), .PB_IN(pins[1]), .PB_OUT(outs[1]), .PB_OE(oes[1]), .PC_IN(c_in),
    .PC_OUT(c_out), .PC_OE(c_oe), .PD_IN(pins[2]), .PD_OUT(outs[2]), .PD_OE(oes[2]),
    .STOP_MODE(stop), .LOW_OSC_ENABLE(low_osc));
  for (genvar g = 0; g < 3; g++) begin : g_port
    pin_board u_pin (.ext(ext[g]), .drv(outs[g]), .oe(oes[g]), .pin(pins[g]));
  end
  pin_board #(.W(3)) u_pin_c (.ext(ec), .drv(c_out), .oe(c_oe), .pin(c_in));
  initial forever #25 clk_sys = ~clk_sys;
  function automatic logic [7:0] port_rd(input logic [7:0] dv, lt, pn);
    return (dv & lt) | (~dv & pn);
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s = 4'hF);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_sys);
    penable <= 1'h1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (n >= 50) miscompares++;
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    #1;
  endtask
  task automatic print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // About fifteen times the expected run
  initial begin
    #200us;
    miscompares++;
    print_verdict;
  end
  initial begin
    void'($urandom(32'hCFB42B94));
    repeat (5) @(posedge clk_sys);
    chk("d_out", 8'hFF, outs[2]);
    rst_n <= 1'h1;
    chk("a_out", 8'h00, outs[0]);
    chk("b_out", 8'h00, outs[1]);
    chk("c_oe", 3'h0, c_oe);
    chk("stop_rst", 1'h0, stop);
    chk("c_out", 3'h0, c_out);
    apb(1'h0, 8'h08, 32'h0);
    chk("c_latch", 3'h7, rd[2:0]);
    for (int p = 0; p < 3; p++) begin
      apb(1'h0, dirs[p], 32'h0);
      chk("dir_rst", 32'h0, rd);
      for (int k = 0; k < 5; k++) begin
        dir = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom);
        lat = 8'($urandom);
        // Alternate-function setup: listed pins output with latch high
        if (k == 2) begin
          dir = roles[p];
          lat = lat | roles[p];
        end
        ext[p] <= 8'($urandom);
        apb(1'h1, dirs[p], {24'h0, dir});
        apb(1'h1, dats[p], {24'h0, lat});
        chk("oe", dir, oes[p]);
        chk("out", lat, outs[p]);
        apb(1'h0, dats[p], 32'h0);
        chk("rd", port_rd(dir, lat, ext[p]), rd);
        apb(1'h1, dats[p], rd);
        chk("rmw", port_rd(dir, lat, ext[p]), outs[p]);
      end
    end
    for (int k = 0; k < 4; k++) begin
      lat = 8'($urandom);
      ec <= 3'($urandom);
      apb(1'h1, 8'h08, {24'h0, lat});
      chk("c_oe", 3'(~lat[2:0]), c_oe);
      apb(1'h0, 8'h30, 32'h0);
      chk("c_pin", ec & lat[2:0], rd[2:0]);
    end
    apb(1'h1, 8'h20, 32'hFF);
    apb(1'h1, 8'h08, 32'h6);
    chk("c_oe", 3'h1, c_oe);
    apb(1'h1, 8'hE0, 32'h90);
    chk("stop_output_enable", 8'hFF, oes[0]);
    chk("stop_set", 1'h1, stop);
    chk("c_stop", 3'h0, c_oe);
    apb(1'h1, 8'hE0, 32'h80);
    chk("stop", 8'h00, oes[0]);
    apb(1'h1, 8'hE0, 32'h0);
    apb(1'h1, 8'h08, 32'h0);
    apb(1'h1, 8'hE4, 32'h40);
    ec <= 3'h7;
    chk("osc", 3'h1, c_oe);
    chk("osc_en", 1'h1, low_osc);
    apb(1'h0, 8'h30, 32'h0);
    chk("osc_rd", 3'h0, rd[2:0]);
    apb(1'h1, 8'hE4, 32'h0);
    apb(1'h1, 8'h08, 32'h7);
    apb(1'h0, 8'h10, 32'h0);
    chk("unmapped_err", 1'h1, err);
    chk("unmapped_rd", 32'h0, rd);
    lat = outs[0];
    apb(1'h1, 8'h14, 32'h5A);
    apb(1'h1, 8'h00, 32'hA5, 4'h0);
    chk("refused", lat, outs[0]);
    chk("err_ok", 1'h0, err);
    @(posedge clk_sys);
    rst_n <= 1'h0;
    #1;
    chk("rst_again", 8'hFF, outs[2]);
    chk("oe_again", 8'h00, oes[2]);
    @(posedge clk_sys);
    rst_n <= 1'h1;
    apb(1'h0, 8'h2C, 32'h0);
    chk("d_dir_again", 32'h0, rd);
    print_verdict;
  end
endmodule
bind four_port_io four_port_io_asserts #(.A_WIDTH(A_WIDTH), .C_WIDTH(C_WIDTH)) u_chk (
  .CLK_SYS(CLK_SYS), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
  .PA_OE(PA_OE), .PB_OUT(PB_OUT), .PC_IN(PC_IN), .PC_OE(PC_OE), .STOP_MODE(STOP_MODE),
  .LOW_OSC_ENABLE(LOW_OSC_ENABLE));
